// File: verilog/mda_pkg.sv
// Purpose: shared constants for the deferral, enable and upper-address block
// Assumes: 25 MHz aclk, 32-bit AXI4-Lite register bus
// Notes: register offsets are word indices, byte address is index times four
package mda_pkg;
  // timing
  localparam int CLK_NS = 40;
  localparam int BIT_NS_10 = 100;
  localparam int BIT_NS_100 = 10;
  localparam int DEFER_LIMIT_BT = 24288;
  localparam int DEFER_CYC_10 = (DEFER_LIMIT_BT * BIT_NS_10) / CLK_NS;
  localparam int DEFER_CYC_100 = (DEFER_LIMIT_BT * BIT_NS_100) / CLK_NS;
  localparam int CNT_W = 17;
  // register map (word indices)
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] CTRL_IDX = 6'h01;
  localparam logic [IDX_W-1:0] STATION_ADDRESS_UPPER_IDX = 6'h02;
  localparam logic [IDX_W-1:0] STAT_IDX = 6'h07;
  // control fields
  localparam int RX_ON_BIT = 2;
  localparam int TX_ON_BIT = 3;
  localparam int DEFERRAL_LIMIT_CHECK_BIT = 5;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // upper address
  localparam logic [15:0] STATION_ADDRESS_UPPER_RST = 16'hffff;
  localparam logic [7:0] EE_STATION_ADDRESS_UPPER_LO = 8'h05;
  localparam logic [7:0] EE_STATION_ADDRESS_UPPER_HI = 8'h06;
  // status fields
  localparam int ST_INIT_BIT = 0;
  localparam int ST_LOADED_BIT = 1;
  localparam int ST_DEFER_BIT = 2;
  localparam int ST_SEND_BIT = 3;
  localparam int ST_ABCNT_LSB = 8;
  // responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    MDA_IDLE = 4'h1,
    MDA_DEFER = 4'h2,
    MDA_SEND = 4'h4,
    MDA_BACK = 4'h8
  } mda_tx_state_t;
endpackage

// File: verilog/mda_defer_if.sv
// Purpose: carrier between transmit control and the deferral timer
// Assumes: single aclk domain
// Notes: limit is in aclk cycles
`timescale 1ns/1ns
interface mda_defer_if;
  import mda_pkg::*;
  logic run;
  logic clear;
  logic check_on;
  logic [CNT_W-1:0] limit;
  logic expired;
  modport ctl (output run, output clear, output check_on, output limit, input expired);
  modport tmr (input run, input clear, input check_on, input limit, output expired);
endinterface

// File: verilog/mda_defer_timer.sv
// Purpose: deferral timer with optional limit check
// Assumes: limit already converted from bit times to aclk cycles
// Notes: count saturates so a long deferral never wraps
`timescale 1ns/1ns
module mda_defer_timer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control side
  mda_defer_if.tmr dif
);
  import mda_pkg::*;

  logic [CNT_W-1:0] count_reg;
  logic expired_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
    end else if (dif.clear) begin
      count_reg <= '0;
    end else if (dif.run && count_reg != '1) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expired_reg <= 1'b0;
    end else begin
      expired_reg <= dif.check_on && !dif.clear && (count_reg > dif.limit);
    end
  end

  assign dif.expired = expired_reg;

  timer_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dif.clear |=> count_reg == '0) else $error("deferral timer not cleared");
  timer_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dif.run && !dif.clear && count_reg < dif.limit |=> count_reg == $past(count_reg) + 1'b1)
    else $error("deferral timer did not advance");
  expire_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    expired_reg |-> $past(count_reg) > $past(dif.limit) && $past(dif.check_on))
    else $error("deferral expired early or with check off");
endmodule

// File: verilog/mda_top.sv
// Purpose: deferral-limit abort, tx/rx enables and upper station address
// Assumes: frame engine, PHY status and EEPROM loader are synchronous to aclk
// Notes: registers reached over AXI4-Lite, one word per index
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
module mda_top #(
  parameter int AW = 8,
  parameter int DEFER_CYC_10 = mda_pkg::DEFER_CYC_10,
  parameter int DEFER_CYC_100 = mda_pkg::DEFER_CYC_100
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // phy status
  input wire logic crs,
  input wire logic collision,
  input wire logic phy_speed_100,
  // transmit frame engine
  input wire logic tx_frame_ready,
  input wire logic tx_done,
  input wire logic backoff_done,
  output logic tx_go,
  output logic tx_abort,
  output logic tx_active,
  // receive path
  input wire logic rx_frame_in,
  output logic rx_accept,
  // eeprom loader
  input wire logic ee_valid,
  input wire logic [7:0] ee_addr,
  input wire logic [7:0] ee_data,
  input wire logic ee_init_done,
  // station address out
  output logic [15:0] station_address_upper
);
  import mda_pkg::*;
  mda_defer_if dif ();
  mda_defer_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .dif(dif)
  );
  // control and address state
  logic tx_on_reg;
  logic rx_on_reg;
  logic deferral_limit_check_reg;
  logic [15:0] station_address_upper_reg;
  logic loaded_reg;
  logic init_reg;
  logic [7:0] abcnt_reg;
  mda_tx_state_t state_reg;
  logic tx_go_reg;
  logic tx_abort_reg;
  logic tx_active_reg;
  logic rx_accept_reg;
  // bus state
  logic awready_reg;
  logic wready_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [IDX_W-1:0] wr_idx_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic aw_take;
  logic w_take;
  logic do_wr;
  logic ar_take;
  logic [IDX_W-1:0] rd_idx;
  logic wr_mapped;
  logic [31:0] rd_word;
  logic rd_mapped;
  assign aw_take = awvalid && awready_reg;
  assign w_take = wvalid && wready_reg;
  assign do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
  assign ar_take = arvalid && arready_reg;
  assign rd_idx = araddr[AW-1:2];
  assign wr_mapped = (wr_idx_reg == CTRL_IDX) || (wr_idx_reg == STATION_ADDRESS_UPPER_IDX) ||
                     (wr_idx_reg == STAT_IDX);
  // write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      aw_full_reg <= 1'b0;
      wr_idx_reg <= '0;
    end else if (aw_take) begin
      awready_reg <= 1'b0;
      aw_full_reg <= 1'b1;
      wr_idx_reg <= awaddr[AW-1:2];
    end else begin
      if (do_wr) begin
        aw_full_reg <= 1'b0;
      end
      awready_reg <= !aw_full_reg && !bvalid_reg;
    end
  end
  // write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b0;
      w_full_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (w_take) begin
      wready_reg <= 1'b0;
      w_full_reg <= 1'b1;
      wdata_reg <= wdata;
      wstrb_reg <= wstrb;
    end else begin
      if (do_wr) begin
        w_full_reg <= 1'b0;
      end
      wready_reg <= !w_full_reg && !bvalid_reg;
    end
  end
  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  // control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_on_reg <= CTRL_RST[TX_ON_BIT];
      rx_on_reg <= CTRL_RST[RX_ON_BIT];
      deferral_limit_check_reg <= CTRL_RST[DEFERRAL_LIMIT_CHECK_BIT];
    end else if (do_wr && wr_idx_reg == CTRL_IDX && wstrb_reg[0]) begin
      tx_on_reg <= wdata_reg[TX_ON_BIT];
      rx_on_reg <= wdata_reg[RX_ON_BIT];
      deferral_limit_check_reg <= wdata_reg[DEFERRAL_LIMIT_CHECK_BIT];
    end
  end
  // initialization done is caught after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_reg <= 1'b0;
    end else if (ee_init_done) begin
      init_reg <= 1'b1;
    end
  end
  // upper station address: eeprom load first, host only after init
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      station_address_upper_reg <= STATION_ADDRESS_UPPER_RST;
      loaded_reg <= 1'b0;
    end else if (!init_reg) begin
      if (ee_valid && ee_addr == EE_STATION_ADDRESS_UPPER_LO) begin
        station_address_upper_reg[7:0] <= ee_data;
        loaded_reg <= 1'b1;
      end else if (ee_valid && ee_addr == EE_STATION_ADDRESS_UPPER_HI) begin
        station_address_upper_reg[15:8] <= ee_data;
        loaded_reg <= 1'b1;
      end
    end else if (do_wr && wr_idx_reg == STATION_ADDRESS_UPPER_IDX) begin
      // host access held off until init_reg, guarding the load
      if (wstrb_reg[0]) begin
        station_address_upper_reg[7:0] <= wdata_reg[7:0];
      end
      if (wstrb_reg[1]) begin
        station_address_upper_reg[15:8] <= wdata_reg[15:8];
      end
    end
  end
  // read decode
  always_comb begin
    rd_word = '0;
    rd_mapped = 1'b1;
    unique case (rd_idx)
      CTRL_IDX: begin
        rd_word[TX_ON_BIT] = tx_on_reg;
        rd_word[RX_ON_BIT] = rx_on_reg;
        rd_word[DEFERRAL_LIMIT_CHECK_BIT] = deferral_limit_check_reg;
      end
      STATION_ADDRESS_UPPER_IDX: begin
        rd_word[15:0] = station_address_upper_reg;
      end
      STAT_IDX: begin
        rd_word[ST_INIT_BIT] = init_reg;
        rd_word[ST_LOADED_BIT] = loaded_reg;
        rd_word[ST_DEFER_BIT] = (state_reg == MDA_DEFER);
        rd_word[ST_SEND_BIT] = (state_reg == MDA_SEND);
        rd_word[ST_ABCNT_LSB +: 8] = abcnt_reg;
      end
      default: begin
        rd_mapped = 1'b0;
      end
    endcase
  end
  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end
  // deferral timer control
  assign dif.run = (state_reg == MDA_DEFER) && crs;
  assign dif.clear = (state_reg != MDA_DEFER);
  assign dif.check_on = deferral_limit_check_reg;
  assign dif.limit = phy_speed_100 ? CNT_W'(DEFER_CYC_100) : CNT_W'(DEFER_CYC_10);
  // transmit sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= MDA_IDLE;
      tx_go_reg <= 1'b0;
      tx_abort_reg <= 1'b0;
      tx_active_reg <= 1'b0;
    end else begin
      tx_go_reg <= 1'b0;
      tx_abort_reg <= 1'b0;
      unique case (state_reg)
        MDA_IDLE: begin
          if (tx_on_reg && tx_frame_ready) begin
            if (crs) begin
              state_reg <= MDA_DEFER;
            end else begin
              state_reg <= MDA_SEND;
              tx_go_reg <= 1'b1;
              tx_active_reg <= 1'b1;
            end
          end
        end
        MDA_DEFER: begin
          if (!tx_on_reg) begin
            state_reg <= MDA_IDLE;
          end else if (dif.expired) begin
            state_reg <= MDA_IDLE;
            tx_abort_reg <= 1'b1;
          end else if (!crs) begin
            state_reg <= MDA_SEND;
            tx_go_reg <= 1'b1;
            tx_active_reg <= 1'b1;
          end
        end
        MDA_SEND: begin
          if (collision) begin
            state_reg <= MDA_BACK;
            tx_active_reg <= 1'b0;
          end else if (tx_done) begin
            state_reg <= MDA_IDLE;
            tx_active_reg <= 1'b0;
          end
        end
        MDA_BACK: begin
          if (backoff_done) begin
            state_reg <= MDA_DEFER;
          end
        end
        default: begin
          state_reg <= MDA_IDLE;
          tx_active_reg <= 1'b0;
        end
      endcase
    end
  end
  // abort counter for status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abcnt_reg <= '0;
    end else if (tx_abort_reg && abcnt_reg != 8'hff) begin
      abcnt_reg <= abcnt_reg + 8'h01;
    end
  end
  // receive gate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_accept_reg <= 1'b0;
    end else begin
      rx_accept_reg <= rx_on_reg && rx_frame_in;
    end
  end
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign tx_go = tx_go_reg;
  assign tx_abort = tx_abort_reg;
  assign tx_active = tx_active_reg;
  assign rx_accept = rx_accept_reg;
  assign station_address_upper = station_address_upper_reg;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  tx_gate_a: assert property (
    tx_go_reg |-> $past(tx_on_reg)) else $error("frame started with transmitter off");
  tx_start_a: assert property (
    state_reg == MDA_IDLE && tx_on_reg && tx_frame_ready && !crs |=> tx_go_reg ##1 tx_active_reg)
    else $error("ready frame not started");
  defer_enter_a: assert property (
    state_reg == MDA_IDLE && tx_on_reg && tx_frame_ready && crs |=> state_reg == MDA_DEFER)
    else $error("carrier did not cause deferral");
  abort_cause_a: assert property (
    tx_abort_reg |-> $past(state_reg == MDA_DEFER) && $past(dif.expired))
    else $error("abort without expired deferral");
  no_abort_off_a: assert property (
    !deferral_limit_check_reg [*3] |-> !tx_abort_reg) else $error("abort while check off");
  rate_limit_a: assert property (
    dif.limit == (phy_speed_100 ? CNT_W'(DEFER_CYC_100) : CNT_W'(DEFER_CYC_10)))
    else $error("wrong deferral limit for line rate");
  rx_gate_a: assert property (
    rx_accept_reg |-> $past(rx_on_reg) && $past(rx_frame_in)) else $error("rx accept mismatch");
  ee_load_a: assert property (
    !init_reg && ee_valid && ee_addr == EE_STATION_ADDRESS_UPPER_HI |=> station_address_upper_reg[15:8] == $past(ee_data))
    else $error("eeprom byte not loaded");
  addr_rsvd_a: assert property (
    ar_take && rd_idx == STATION_ADDRESS_UPPER_IDX |=> rvalid_reg && rdata_reg[31:16] == 16'h0000)
    else $error("reserved address bits not zero");
  host_guard_a: assert property (
    !init_reg && !ee_valid |=> $stable(station_address_upper_reg)) else $error("address changed before init");
  go_c: cover property (tx_go_reg);
  abort_c: cover property (tx_abort_reg);
  backoff_c: cover property (state_reg == MDA_BACK ##1 state_reg == MDA_DEFER);
  ee_c: cover property (ee_valid && ee_addr == EE_STATION_ADDRESS_UPPER_LO && !init_reg);
endmodule

// File: verification/mda_phy_model.sv
// Purpose: far side model: carrier, collision, frame timing, back-off and EEPROM load
// Assumes: tb steers carrier and collision through crs_req and col_req
// Notes: frame lasts 8 cycles, back-off 6 cycles after collision
`timescale 1ns/1ns
module mda_phy_model #(
  parameter logic [7:0] EE_LO = 8'h5a,
  parameter logic [7:0] EE_HI = 8'hc3
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // steering from tb
  input wire logic crs_req,
  input wire logic col_req,
  // line side
  input wire logic tx_go,
  output logic crs,
  output logic collision,
  output logic tx_done,
  output logic backoff_done,
  // eeprom loader
  output logic ee_valid,
  output logic [7:0] ee_addr,
  output logic [7:0] ee_data,
  output logic ee_init_done
);
  int step;
  int snd;
  int bo;
  assign crs = crs_req;
  // two address bytes, then init finished
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step <= 0;
      ee_valid <= 1'b0;
      ee_addr <= 8'h00;
      ee_data <= 8'h00;
      ee_init_done <= 1'b0;
    end else begin
      step <= (step < 8) ? step + 1 : step;
      ee_valid <= (step == 2) || (step == 3);
      ee_addr <= (step == 2) ? 8'h05 : 8'h06;
      ee_data <= (step == 2) ? EE_LO : ((step == 3) ? EE_HI : ~ee_data);
      ee_init_done <= (step >= 5);
    end
  end
  // frame on the line, collision and back-off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snd <= 0;
      bo <= 0;
      tx_done <= 1'b0;
      collision <= 1'b0;
      backoff_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      collision <= 1'b0;
      backoff_done <= 1'b0;
      if (tx_go) snd <= 1;
      else if (snd != 0) snd <= snd + 1;
      if (snd == 2 && col_req) begin
        collision <= 1'b1;
        snd <= 0;
        bo <= 1;
      end else if (snd == 8) begin
        tx_done <= 1'b1;
        snd <= 0;
      end
      if (bo != 0) bo <= bo + 1;
      if (bo == 6) begin
        backoff_done <= 1'b1;
        bo <= 0;
      end
    end
  end
endmodule

// File: verification/tb.sv
// Purpose: self-checking bench for deferral limit, enables and upper address
// Assumes: limits shortened to 40 (10M) and 20 (100M) cycles
// Notes: pulse counters run on posedge, cycle index on negedge
`timescale 1ns/1ns
module tb;
  import mda_pkg::*;
  localparam int L10 = 40;
  localparam int L100 = 20;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, crs, collision, phy_speed_100;
  logic tx_frame_ready, tx_done, backoff_done, tx_go, tx_abort, tx_active;
  logic rx_frame_in, rx_accept, ee_valid, ee_init_done, crs_req, col_req;
  logic [7:0] awaddr, araddr, ee_addr, ee_data;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] station_address_upper;
  int fail_count, tests_run, cyc, go_cnt, ab_cnt, ab_cyc, bo_cyc;
  mda_top #(.AW(8), .DEFER_CYC_10(L10), .DEFER_CYC_100(L100)) dut (.aclk, .aresetn,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .crs,
    .collision, .phy_speed_100, .tx_frame_ready, .tx_done, .backoff_done, .tx_go,
    .tx_abort, .tx_active, .rx_frame_in, .rx_accept, .ee_valid, .ee_addr, .ee_data,
    .ee_init_done, .station_address_upper);
  mda_phy_model phy (.aclk, .aresetn, .crs_req, .col_req, .tx_go, .crs, .collision,
    .tx_done, .backoff_done, .ee_valid, .ee_addr, .ee_data, .ee_init_done);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(negedge aclk) cyc++;
  always @(posedge aclk) begin
    if (tx_go === 1'b1) go_cnt++;
    if (tx_abort === 1'b1) begin
      ab_cnt++;
      ab_cyc = cyc;
    end
    if (backoff_done === 1'b1) bo_cyc = cyc;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stuck(input int n);
    if (n >= 100) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
      final_report();
    end
  endtask
  function automatic logic [7:0] ba(input logic [IDX_W-1:0] idx);
    return {idx, 2'b00};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    rs = bresp;
    stuck(n);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    v = rdata;
    rs = rresp;
    stuck(n);
  endtask
  task automatic wait_cnt(ref int c, input int lim);
    int n;
    n = 0;
    while (c == 0 && n < lim) begin
      @(posedge aclk);
      n++;
    end
    stuck((n >= lim) ? 100 : 0);
  endtask
  task automatic ctl(input logic [31:0] v);
    wr(ba(CTRL_IDX), v, r);
  endtask
  task automatic t_regs();
    rd(ba(STATION_ADDRESS_UPPER_IDX), d, r);
    chk(d, 32'h0000c35a);
    chk(r, RESP_OKAY);
    rd(ba(STAT_IDX), d, r);
    chk(d, (32'h1 << ST_INIT_BIT) | (32'h1 << ST_LOADED_BIT));
    rd(ba(CTRL_IDX), d, r);
    chk(d, CTRL_RST);
    wr(ba(STATION_ADDRESS_UPPER_IDX), 32'hdead_beef, r);
    rd(ba(STATION_ADDRESS_UPPER_IDX), d, r);
    chk(d, 32'h0000beef);
    chk(station_address_upper, 16'hbeef);
    rd(8'hfc, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    wr(8'hfc, 32'h1, r);
    chk(r, RESP_SLVERR);
    $display("test regs done");
  endtask
  task automatic t_txon();
    go_cnt = 0;
    ctl(32'h0);
    tx_frame_ready <= 1'b1;
    repeat (20) @(posedge aclk);
    chk(go_cnt, 0);
    ctl(32'h1 << TX_ON_BIT);
    wait_cnt(go_cnt, 20);
    chk(tx_active, 1'b1);
    tx_frame_ready <= 1'b0;
    repeat (14) @(posedge aclk);
    chk(tx_active, 1'b0);
    $display("test tx enable done");
  endtask
  task automatic t_limit(input logic spd, input int lim);
    int st;
    ctl((32'h1 << TX_ON_BIT) | (32'h1 << DEFERRAL_LIMIT_CHECK_BIT));
    go_cnt = 0;
    ab_cnt = 0;
    phy_speed_100 <= spd;
    crs_req <= 1'b1;
    tx_frame_ready <= 1'b1;
    st = cyc;
    wait_cnt(ab_cnt, lim + 30);
    tx_frame_ready <= 1'b0;
    chk((ab_cyc - st > lim) && (ab_cyc - st <= lim + 6), 1);
    ctl(32'h0);
    crs_req <= 1'b0;
    chk(go_cnt, 0);
    chk(ab_cnt, 1);
    $display("test limit done");
  endtask
  task automatic t_nocheck();
    ctl(32'h1 << TX_ON_BIT);
    go_cnt = 0;
    ab_cnt = 0;
    crs_req <= 1'b1;
    tx_frame_ready <= 1'b1;
    repeat (100) @(posedge aclk);
    chk(ab_cnt, 0);
    crs_req <= 1'b0;
    wait_cnt(go_cnt, 10);
    tx_frame_ready <= 1'b0;
    repeat (14) @(posedge aclk);
    $display("test no limit done");
  endtask
  task automatic t_collide();
    ctl((32'h1 << TX_ON_BIT) | (32'h1 << DEFERRAL_LIMIT_CHECK_BIT));
    go_cnt = 0;
    ab_cnt = 0;
    bo_cyc = 0;
    phy_speed_100 <= 1'b1;
    col_req <= 1'b1;
    crs_req <= 1'b1;
    tx_frame_ready <= 1'b1;
    repeat (12) @(posedge aclk);
    crs_req <= 1'b0;
    wait_cnt(go_cnt, 10);
    crs_req <= 1'b1;
    wait_cnt(ab_cnt, 80);
    tx_frame_ready <= 1'b0;
    col_req <= 1'b0;
    chk(bo_cyc != 0 && ab_cyc - bo_cyc > L100, 1);
    ctl(32'h0);
    crs_req <= 1'b0;
    $display("test collision done");
  endtask
  task automatic t_rx();
    ctl(32'h1 << RX_ON_BIT);
    rx_frame_in <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(rx_accept, 1'b1);
    ctl(32'h0);
    repeat (2) @(posedge aclk);
    chk(rx_accept, 1'b0);
    rx_frame_in <= 1'b0;
    rd(ba(STAT_IDX), d, r);
    chk(d, (32'h1 << ST_INIT_BIT) | (32'h1 << ST_LOADED_BIT) | (32'h3 << ST_ABCNT_LSB));
    $display("test rx enable done");
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, crs_req, col_req} = '0;
    {phy_speed_100, tx_frame_ready, rx_frame_in} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(station_address_upper, STATION_ADDRESS_UPPER_RST);
    repeat (12) @(posedge aclk);
    t_regs();
    t_txon();
    t_limit(1'b1, L100);
    t_limit(1'b0, L10);
    t_nocheck();
    t_collide();
    t_rx();
    final_report();
  end
endmodule
